// ---- adu_defs.svh ----
// Purpose: constants for the assist data upload sequencer
// Assumes: included by bare name
// Notes: counts are in bytes unless named otherwise
`ifndef ADU_DEFS_SVH
`define ADU_DEFS_SVH
`define ADU_BLK_BYTES  10'h0200
`define ADU_BLK_SHIFT  9
`define ADU_CODE_NEXT  2'h0
`define ADU_CODE_RETRY 2'h1
`define ADU_CODE_ABORT 2'h2
`define ADU_CLS_FLASH  1'b1
`define ADU_CLS_GEN    1'b0
`define ADU_BUF_DEPTH  2
`endif

// ---- adu_pkg.sv ----
// Purpose: types for the assist data upload sequencer
// Assumes: nothing
// Notes: states gray coded from idle through erase, data and drain to reply
package adu_pkg;
    typedef enum logic [0:0] {
        ADU_K_BLOCK = 1'b0,
        ADU_K_END   = 1'b1
    } adu_kind_t;
    typedef struct packed {
        adu_kind_t   kind;
        logic [15:0] seq;
        logic [9:0]  len;
    } adu_cmd_t;
    typedef struct packed {
        logic        cls;
        logic [1:0]  code;
        logic [15:0] seq;
    } adu_rsp_t;
    typedef struct packed {
        logic [7:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [7:0] gnss;
        logic [7:0] sv;
    } adu_orbit_t;
    typedef enum logic [2:0] {
        ADU_S_IDLE    = 3'h0,
        ADU_S_ERASE   = 3'h1,
        ADU_S_DATA    = 3'h3,
        ADU_S_DRAIN   = 3'h2,
        ADU_S_REPLY   = 3'h6,
        ADU_S_PREP    = 3'h7,
        ADU_S_DISCARD = 3'h5
    } adu_state_t;
endpackage : adu_pkg

// ---- adu_seq.sv ----
// Purpose: receiver side of flash upload of assistance data
// Assumes: messages already deframed into header and payload bytes
// Notes: block address is seq times block size
//
// What this block does
// - reply says next, resend or abort
// - end reply waits for data preparation while an upload is open, else abort at once
// - shorter final block is accepted
// - flash replies use their own class
// - first block erases old stored data
// - blocks numbered from zero upward
// - out-of-sequence blocks are rejected
// - orbit message names satellite and date
// - orbit messages ordered date, gnss, sv
`timescale 1ns/1ps
`include "adu_defs.svh"
module adu_seq
    import adu_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // message headers
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire adu_cmd_t          cmd,
    // block payload
    input  wire logic              pl_valid,
    output logic                   pl_ready,
    input  wire logic [7:0]        pl_data,
    input  wire logic              pl_last,
    // flash store
    output logic                   erase_req,
    input  wire logic              erase_done,
    output logic                   fl_valid,
    input  wire logic              fl_ready,
    output logic [ADDR_W-1:0]      fl_addr,
    output logic [7:0]             fl_data,
    output logic                   prep_start,
    input  wire logic              prep_done,
    output logic                   store_ok,
    // replies
    output logic                   rsp_valid,
    input  wire logic              rsp_ready,
    output adu_rsp_t               rsp,
    // offline orbit headers
    input  wire logic              orb_valid,
    output logic                   orb_ready,
    input  wire adu_orbit_t        orb,
    input  wire logic              orb_err_clr,
    output logic                   orb_order_err
);
    adu_state_t state_r, state_nxt;
    logic [15:0] exp_r, seq_r;
    logic [9:0]  cnt_r, len_r;
    logic        bad_r, started_r, store_r, prep_r;
    logic [1:0]  code_r;
    adu_rsp_t    rsp_r;
    logic [32:0] orb_last_r;
    logic        orb_have_r, orb_err_r;

    wire cmd_take  = cmd_valid && cmd_ready;
    wire pl_take   = pl_valid && pl_ready;
    wire is_blk    = cmd.kind == ADU_K_BLOCK;
    wire len_ok    = cmd.len != 10'h000 && cmd.len <= `ADU_BLK_BYTES;
    wire seq_first = cmd.seq == 16'h0000;
    wire seq_ok    = seq_first || (started_r && cmd.seq == exp_r);
    wire in_data   = state_r == ADU_S_DATA;
    wire room      = cnt_r < len_r;
    wire last_bad  = pl_last && ((cnt_r + 10'h001) != len_r);

    // two-entry buffer toward flash
    logic [ADDR_W-1:0] b_addr_r [`ADU_BUF_DEPTH];
    logic [7:0]        b_dat_r  [`ADU_BUF_DEPTH];
    logic              wp_r, rp_r;
    logic [1:0]        fill_r;
    wire b_in_rdy = fill_r != 2'h2;
    wire b_push   = in_data && pl_take && room;
    wire b_pop    = fl_valid && fl_ready;
    wire b_empty  = fill_r == 2'h0;
    wire [ADDR_W-1:0] wr_addr =
        ADDR_W'({seq_r, 9'h000}) + ADDR_W'(cnt_r);

    assign cmd_ready = state_r == ADU_S_IDLE;
    // overlong payload is swallowed, not written
    assign pl_ready  = (in_data && (b_in_rdy || !room))
                     || state_r == ADU_S_DISCARD;
    assign erase_req = state_r == ADU_S_ERASE;
    assign fl_valid  = !b_empty;
    assign fl_addr   = b_addr_r[rp_r];
    assign fl_data   = b_dat_r[rp_r];
    assign prep_start = prep_r;
    assign store_ok  = store_r;
    assign rsp_valid = state_r == ADU_S_REPLY;
    assign rsp       = rsp_r;
    assign orb_ready = 1'b1;
    assign orb_order_err = orb_err_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            wp_r   <= 1'b0;
            rp_r   <= 1'b0;
            fill_r <= 2'h0;
        end else begin
            if (b_push) begin
                b_addr_r[wp_r] <= wr_addr;
                b_dat_r[wp_r]  <= pl_data;
                wp_r <= ~wp_r;
            end
            if (b_pop)
                rp_r <= ~rp_r;
            fill_r <= fill_r + {1'b0, b_push} - {1'b0, b_pop};
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ADU_S_IDLE: begin
                if (cmd_take) begin
                    if (!is_blk)
                        state_nxt = started_r ? ADU_S_PREP : ADU_S_REPLY;
                    else if (!len_ok || !seq_ok)
                        state_nxt = ADU_S_DISCARD;
                    else if (seq_first)
                        state_nxt = ADU_S_ERASE;
                    else
                        state_nxt = ADU_S_DATA;
                end
            end
            ADU_S_ERASE:
                if (erase_done)
                    state_nxt = ADU_S_DATA;
            ADU_S_DATA:
                if (pl_take && pl_last)
                    state_nxt = ADU_S_DRAIN;
            ADU_S_DRAIN:
                if (b_empty)
                    state_nxt = ADU_S_REPLY;
            ADU_S_DISCARD:
                if (pl_take && pl_last)
                    state_nxt = ADU_S_REPLY;
            ADU_S_PREP:
                if (prep_done)
                    state_nxt = ADU_S_REPLY;
            ADU_S_REPLY:
                if (rsp_ready)
                    state_nxt = ADU_S_IDLE;
            default:
                state_nxt = ADU_S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst)
            state_r <= ADU_S_IDLE;
        else
            state_r <= state_nxt;
    end

    // upload bookkeeping
    always_ff @(posedge mclk) begin
        if (srst) begin
            exp_r     <= 16'h0000;
            seq_r     <= 16'h0000;
            cnt_r     <= 10'h000;
            len_r     <= 10'h000;
            bad_r     <= 1'b0;
            started_r <= 1'b0;
            store_r   <= 1'b0;
            prep_r    <= 1'b0;
            code_r    <= `ADU_CODE_NEXT;
        end else begin
            prep_r <= 1'b0;
            if (cmd_take) begin
                seq_r <= cmd.seq;
                len_r <= cmd.len;
                cnt_r <= 10'h000;
                bad_r <= 1'b0;
                if (!is_blk) begin
                    prep_r <= started_r;
                    code_r <= started_r ? `ADU_CODE_NEXT : `ADU_CODE_ABORT;
                end else if (!len_ok) begin
                    code_r <= `ADU_CODE_RETRY;
                end else if (!seq_ok) begin
                    code_r    <= `ADU_CODE_ABORT;
                    started_r <= 1'b0;
                end else if (seq_first) begin
                    // old data gone from the first block on
                    store_r   <= 1'b0;
                    started_r <= 1'b1;
                    exp_r     <= 16'h0000;
                end
            end
            if (in_data && pl_take) begin
                cnt_r <= cnt_r + 10'h001;
                // short last block fine if it matches its header
                if (!room || last_bad)
                    bad_r <= 1'b1;
            end
            if (state_r == ADU_S_DRAIN && b_empty) begin
                code_r <= bad_r ? `ADU_CODE_RETRY : `ADU_CODE_NEXT;
                if (!bad_r)
                    exp_r <= exp_r + 16'h0001;
            end
            if (state_r == ADU_S_PREP && prep_done) begin
                store_r   <= 1'b1;
                started_r <= 1'b0;
            end
        end
    end

    // reply word, flash class only
    always_ff @(posedge mclk) begin
        if (srst)
            rsp_r <= '0;
        else if (state_r != ADU_S_REPLY && state_nxt == ADU_S_REPLY) begin
            rsp_r.cls  <= `ADU_CLS_FLASH;
            rsp_r.code <= (state_r == ADU_S_DRAIN)
                        ? (bad_r ? `ADU_CODE_RETRY : `ADU_CODE_NEXT)
                        : (state_r == ADU_S_IDLE) ? `ADU_CODE_ABORT
                        : (state_r == ADU_S_PREP) ? `ADU_CODE_NEXT : code_r;
            rsp_r.seq  <= (state_r == ADU_S_IDLE) ? cmd.seq : seq_r;
        end
    end

    // orbit order watch: date, then gnss, then sv, strictly rising
    wire [32:0] orb_key = {orb.year, orb.month, orb.day, orb.gnss, orb.sv};
    wire orb_take = orb_valid && orb_ready;
    wire orb_bad  = orb_take && orb_have_r && orb_key <= orb_last_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            orb_last_r <= 33'h0_0000_0000;
            orb_have_r <= 1'b0;
            orb_err_r  <= 1'b0;
        end else begin
            if (orb_take) begin
                orb_last_r <= orb_key;
                orb_have_r <= 1'b1;
            end
            // a new fault beats a clear in the same cycle
            if (orb_bad)
                orb_err_r <= 1'b1;
            else if (orb_err_clr)
                orb_err_r <= 1'b0;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_prep_pulse;
        prep_start ##1 !prep_start;
    endsequence
    sequence s_blk_start;
        cmd_take && is_blk && len_ok && seq_first;
    endsequence

    property p_erase_first;
        s_blk_start |=> !store_ok && erase_req;
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("no erase on first block");

    property p_reject_seq;
        cmd_take && is_blk && len_ok && !seq_ok
            |=> state_r == ADU_S_DISCARD && !fl_valid;
    endproperty
    a_reject_seq: assert property (p_reject_seq) else $error("stray block accepted");

    property p_seq_step;
        state_r == ADU_S_DRAIN && b_empty && !bad_r
            |=> exp_r == $past(exp_r) + 16'h0001;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequence did not step");

    property p_short_ok;
        in_data && pl_take && pl_last && !bad_r && room
            && (cnt_r + 10'h001) == len_r
            |=> state_r == ADU_S_DRAIN && !bad_r;
    endproperty
    a_short_ok: assert property (p_short_ok) else $error("good block marked bad");

    property p_flash_cls;
        rsp_valid |-> rsp.cls == `ADU_CLS_FLASH;
    endproperty
    a_flash_cls: assert property (p_flash_cls) else $error("reply class wrong");

    property p_end_prep;
        cmd_take && !is_blk && started_r |=> s_prep_pulse;
    endproperty
    a_end_prep: assert property (p_end_prep) else $error("no prep after end");

    property p_wait_prep;
        state_r == ADU_S_PREP && !prep_done |=> !rsp_valid;
    endproperty
    a_wait_prep: assert property (p_wait_prep) else $error("reply before prep done");

    property p_code_set;
        rsp_valid |-> rsp.code != 2'h3;
    endproperty
    a_code_set: assert property (p_code_set) else $error("reply code undefined");

    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("reply dropped");

    property p_orb_order;
        orb_bad |=> orb_order_err;
    endproperty
    a_orb_order: assert property (p_orb_order) else $error("order fault lost");
endmodule : adu_seq

// ---- adu_flash_model.sv ----
// Purpose: flash store and data preparation behind the sequencer
// Assumes: one mclk domain, sequencer erase and write handshakes
// Notes: write ready toggles every cycle so the buffer must hold words
`timescale 1ns/1ps
module adu_flash_model (
    // clock
    input  wire logic        mclk,
    // erase
    input  wire logic        erase_req,
    output logic             erase_done,
    // writes
    input  wire logic        fl_valid,
    output logic             fl_ready,
    input  wire logic [19:0] fl_addr,
    // preparation
    input  wire logic        prep_start,
    output logic             prep_done,
    // tallies for the bench
    output int               n_erase,
    output int               n_wr,
    output logic [19:0]      last_addr
);
    int   etm = 0;
    int   ptm = 0;
    logic tog = 1'b0;
    initial begin
        erase_done = 1'b0;
        prep_done = 1'b0;
        n_erase = 0;
        n_wr = 0;
        last_addr = 20'h0_0000;
    end
    assign fl_ready = tog;
    always @(posedge mclk) begin
        tog <= ~tog;
        etm <= erase_req ? etm + 1 : 0;
        erase_done <= erase_req && etm == 3;
        if (erase_req && etm == 0) begin
            n_erase <= n_erase + 1;
        end
        if (fl_valid && fl_ready) begin
            n_wr <= n_wr + 1;
            last_addr <= fl_addr;
        end
        // slow on purpose: the end reply has to wait for this
        ptm <= prep_start ? 30 : (ptm > 0 ? ptm - 1 : 0);
        prep_done <= ptm == 1;
    end
endmodule : adu_flash_model

// ---- adu_seq_tb_top.sv ----
// Purpose: self-checking bench playing the host of the sequencer
// Assumes: flash model on the store side
// Notes: replies are held off two cycles to see that they stand
`timescale 1ns/1ps
`include "adu_defs.svh"
module adu_seq_tb_top
    import adu_pkg::*;
;
    logic        mclk = 1'b0, srst = 1'b1, cmd_valid = 1'b0;
    logic        pl_valid = 1'b0, pl_last = 1'b0, rsp_ready = 1'b0;
    logic        orb_valid = 1'b0, orb_err_clr = 1'b0;
    logic [7:0]  pl_data = 8'h00;
    adu_cmd_t    cmd = '0;
    adu_orbit_t  orb = '0;
    logic        cmd_ready, pl_ready, erase_req, erase_done, fl_valid, fl_ready;
    logic        prep_start, prep_done, store_ok, rsp_valid, orb_ready, orb_order_err;
    logic [19:0] fl_addr, last_addr;
    logic [7:0]  fl_data;
    adu_rsp_t    rsp;
    int          n_erase, n_wr;
    logic [7:0]  last_data = 8'h00;
    int          fail_count = 0;
    int          tests_run = 0;
    always #4 mclk = ~mclk;
    adu_seq i_dut (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data),
        .pl_last(pl_last), .erase_req(erase_req), .erase_done(erase_done),
        .fl_valid(fl_valid), .fl_ready(fl_ready), .fl_addr(fl_addr), .fl_data(fl_data),
        .prep_start(prep_start), .prep_done(prep_done), .store_ok(store_ok),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .orb_valid(orb_valid),
        .orb_ready(orb_ready), .orb(orb), .orb_err_clr(orb_err_clr),
        .orb_order_err(orb_order_err));
    adu_flash_model i_flash (.mclk(mclk), .erase_req(erase_req), .erase_done(erase_done),
        .fl_valid(fl_valid), .fl_ready(fl_ready), .fl_addr(fl_addr),
        .prep_start(prep_start), .prep_done(prep_done), .n_erase(n_erase), .n_wr(n_wr),
        .last_addr(last_addr));
    // last byte that really reached the store
    always @(posedge mclk)
        if (fl_valid && fl_ready)
            last_data <= fl_data;
    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk_rsp(input adu_rsp_t g, input adu_rsp_t e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: reply %h, want %h", $time, g, e);
        end
    endtask : chk_rsp
    task automatic chk_val(input logic [19:0] g, input logic [19:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: value %h, want %h", $time, g, e);
        end
    endtask : chk_val
    function automatic adu_rsp_t fr(input logic [1:0] c, input logic [15:0] s);
        return '{`ADU_CLS_FLASH, c, s};
    endfunction : fr
    // ready is sampled mid-cycle, inputs only move after rising edges
    task automatic send_hdr(input adu_kind_t k, input logic [15:0] s, input logic [9:0] n);
        logic r;
        cmd_valid <= 1'b1;
        cmd <= '{k, s, n};
        do begin
            @(negedge mclk);
            r = cmd_ready;
            @(posedge mclk);
        end while (r !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : send_hdr
    task automatic send_pl(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            pl_valid <= 1'b1;
            pl_data <= i[7:0];
            pl_last <= (i == n - 1);
            do begin
                @(negedge mclk);
                r = pl_ready;
                @(posedge mclk);
            end while (r !== 1'b1);
        end
        pl_valid <= 1'b0;
        pl_last <= 1'b0;
    endtask : send_pl
    task automatic get_rsp(input adu_rsp_t e);
        logic     r;
        adu_rsp_t g;
        do begin
            @(negedge mclk);
            r = rsp_valid;
            @(posedge mclk);
        end while (r !== 1'b1);
        // reply seen, ready held back so it has to stand
        repeat (2) @(posedge mclk);
        rsp_ready <= 1'b1;
        @(negedge mclk);
        r = rsp_valid;
        g = rsp;
        @(posedge mclk);
        rsp_ready <= 1'b0;
        chk_val(20'(r), 20'h0_0001);
        chk_rsp(g, e);
    endtask : get_rsp
    task automatic send_orb(input adu_orbit_t o, input logic e);
        orb_valid <= 1'b1;
        orb <= o;
        @(posedge mclk);
        orb_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk_val(20'(orb_order_err), 20'(e));
        @(posedge mclk);
    endtask : send_orb
    task automatic s_upload();
        int e0;
        int w0;
        e0 = n_erase;
        w0 = n_wr;
        send_hdr(ADU_K_BLOCK, 16'h0000, `ADU_BLK_BYTES);
        send_pl(512);
        get_rsp(fr(`ADU_CODE_NEXT, 16'h0000));
        chk_val(20'(n_erase - e0), 20'h0_0001);
        chk_val(20'(last_data), 20'h0_00ff);
        send_hdr(ADU_K_BLOCK, 16'h0001, 10'h0003);
        send_pl(3);
        get_rsp(fr(`ADU_CODE_NEXT, 16'h0001));
        chk_val(20'(last_data), 20'h0_0002);
        chk_val(last_addr, 20'h0_0202);
        chk_val(20'(n_wr - w0), 20'h0_0203);
        chk_val(20'(store_ok), 20'h0_0000);
        send_hdr(ADU_K_END, 16'h0002, 10'h0000);
        get_rsp(fr(`ADU_CODE_NEXT, 16'h0002));
        chk_val(20'(store_ok), 20'h0_0001);
    endtask : s_upload
    task automatic s_badseq();
        int w0;
        w0 = n_wr;
        send_hdr(ADU_K_BLOCK, 16'h0000, 10'h0001);
        send_pl(1);
        get_rsp(fr(`ADU_CODE_NEXT, 16'h0000));
        chk_val(20'(store_ok), 20'h0_0000);
        send_hdr(ADU_K_BLOCK, 16'h0005, 10'h0001);
        send_pl(1);
        get_rsp(fr(`ADU_CODE_ABORT, 16'h0005));
        chk_val(20'(n_wr - w0), 20'h0_0001);
        send_hdr(ADU_K_END, 16'h0007, 10'h0000);
        get_rsp(fr(`ADU_CODE_ABORT, 16'h0007));
    endtask : s_badseq
    // extra, missing or oversized payload is asked again
    task automatic s_badlen();
        send_hdr(ADU_K_BLOCK, 16'h0000, 10'h0002);
        send_pl(3);
        get_rsp(fr(`ADU_CODE_RETRY, 16'h0000));
        chk_val(20'(last_data), 20'h0_0001);
        send_hdr(ADU_K_BLOCK, 16'h0000, 10'h0003);
        send_pl(2);
        get_rsp(fr(`ADU_CODE_RETRY, 16'h0000));
        send_hdr(ADU_K_BLOCK, 16'h0000, 10'h0201);
        send_pl(1);
        get_rsp(fr(`ADU_CODE_RETRY, 16'h0000));
        send_hdr(ADU_K_BLOCK, 16'h0000, 10'h0002);
        send_pl(2);
        get_rsp(fr(`ADU_CODE_NEXT, 16'h0000));
    endtask : s_badlen
    task automatic s_orbit();
        send_orb('{8'h18, 4'h1, 5'h05, 8'h00, 8'h03}, 1'b0);
        send_orb('{8'h18, 4'h1, 5'h05, 8'h01, 8'h01}, 1'b0);
        send_orb('{8'h18, 4'h1, 5'h05, 8'h01, 8'h01}, 1'b1);
        orb_err_clr <= 1'b1;
        @(posedge mclk);
        orb_err_clr <= 1'b0;
        send_orb('{8'h19, 4'h1, 5'h01, 8'h00, 8'h00}, 1'b0);
        send_orb('{8'h19, 4'h1, 5'h00, 8'h05, 8'h05}, 1'b1);
    endtask : s_orbit
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        s_upload();
        s_badseq();
        s_badlen();
        s_orbit();
        print_verdict();
    end
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule : adu_seq_tb_top
